// ==== design/irrx_decoder.v ====
// Infrared remote receiver: serial frame check, code match and function outputs
//
// Behaviour
// - All timing derives from one divided oscillator tick near 38 kHz.
// - A command acts only when received match bits 1-2 equal their pins (large) or match bit 1 is high and bits 2-3 equal their pins.
// - Hold outputs stay high while matching continuous commands keep arriving.
// - Single-pulse outputs go high on a command and fall after about 107 ms.
// - Each toggle output is a flip-flop inverted on each matching command.
// - Several keys in one command drive several outputs high at once.
// - Large variant decodes 18 functions with toggles; small variant decodes 10.
// - Dependent variant clears toggle output 1 while hold output 1 or 2 is high.
// - Each command arrives twice; bitwise mismatch restarts reception.
// - Hold outputs fall about 160 ms after the last valid hold command.
`timescale 1ns/100ps
`include "irrx_map.vh"
module irrx_decoder #(
  parameter VARIANT    = `IRRX_VAR_LARGE,
  parameter OSC_DIV    = `IRRX_OSC_DIV,
  parameter BIT_TICKS  = `IRRX_BIT_TICKS,
  parameter GAP_TICKS  = `IRRX_GAP_TICKS,
  parameter SP_TICKS   = `IRRX_SP_TICKS,
  parameter HOLD_TICKS = `IRRX_HOLD_TICKS
) (
  // Clock and reset
  input  wire       clk,
  input  wire       resetn,
  // Demodulated serial command
  input  wire       rx_in,
  // Match-code pins
  input  wire       match_bit_one,
  input  wire       match_bit_two,
  input  wire       match_bit_three,
  // Function outputs
  output reg  [5:0] hold_function_out,
  output reg  [9:0] single_pulse_out,
  output reg  [1:0] toggle_function_out
);

  // ==========================================================
  // Local constants
  localparam [1:0]  ST_IDLE  = 2'h0;
  localparam [1:0]  ST_START = 2'h1;
  localparam [1:0]  ST_DATA  = 2'h2;
  // Whole-number forms first, then cut to the counter widths on purpose
  localparam integer DIV_LAST_I = OSC_DIV - 1;
  localparam integer BIT_LAST_I = BIT_TICKS - 1;
  localparam integer HALF_BIT_I = BIT_TICKS / 2 - 1;
  localparam integer GAP_MAX_I  = GAP_TICKS;
  localparam integer LAST_BIT_I = `IRRX_FRAME_BITS - 1;
  localparam integer SP_T_I     = SP_TICKS;
  localparam integer HOLD_T_I   = HOLD_TICKS;
  localparam [9:0]  DIV_LAST = DIV_LAST_I[9:0];
  localparam [7:0]  BIT_LAST = BIT_LAST_I[7:0];
  localparam [7:0]  HALF_BIT = HALF_BIT_I[7:0];
  localparam [7:0]  GAP_MAX  = GAP_MAX_I[7:0];
  localparam [3:0]  LAST_BIT = LAST_BIT_I[3:0];
  localparam [12:0] SP_T     = SP_T_I[12:0];
  localparam [12:0] HOLD_T   = HOLD_T_I[12:0];
  localparam        IS_LARGE = (VARIANT == `IRRX_VAR_LARGE);
  localparam        IS_DEP   = (VARIANT == `IRRX_VAR_DEP);
  localparam [5:0]  HOLD_MSK = IS_LARGE ? 6'h3F : 6'h1F;
  localparam [5:0]  SEL1_MSK = IS_LARGE ? 6'h3F : (IS_DEP ? 6'h07 : 6'h1F);
  localparam [3:0]  SEL2_MSK = IS_LARGE ? 4'hF : 4'h0;
  localparam [1:0]  TGL_MSK  = (IS_LARGE || IS_DEP) ? 2'h3 : 2'h0;

  // ==========================================================
  // Oscillator tick
  reg [9:0] div_ff;
  reg       tick_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      div_ff  <= 10'h000;
      tick_ff <= 1'b0;
    end else if (div_ff == DIV_LAST) begin
      div_ff  <= 10'h000;
      tick_ff <= 1'b1;
    end else begin
      div_ff  <= div_ff + 10'h001;
      tick_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Input synchronisers
  reg       rx_s1_ff;
  reg       rx_s2_ff;
  reg       rx_prev_ff;
  reg [2:0] mt_s1_ff;
  reg [2:0] mt_s2_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_s1_ff   <= 1'b0;
      rx_s2_ff   <= 1'b0;
      rx_prev_ff <= 1'b0;
      mt_s1_ff   <= 3'h0;
      mt_s2_ff   <= 3'h0;
    end else begin
      rx_s1_ff   <= rx_in;
      rx_s2_ff   <= rx_s1_ff;
      rx_prev_ff <= rx_s2_ff;
      mt_s1_ff   <= {match_bit_one, match_bit_two, match_bit_three};
      mt_s2_ff   <= mt_s1_ff;
    end
  end

  // ==========================================================
  // Frame reception
  reg  [1:0]  st_ff;
  reg  [7:0]  cnt_ff;
  reg  [3:0]  bitn_ff;
  reg         pass_ff;
  reg  [7:0]  gap_ff;
  reg         done_ff;
  wire        sample = tick_ff && (cnt_ff == 8'h00);
  wire        shift_en = (st_ff == ST_DATA) && sample;
  wire [11:0] frame;
  wire        old_bit;

  irrx_shift #(
    .WIDTH    (`IRRX_FRAME_BITS)
  ) u_shift (
    .clk      (clk),
    .resetn   (resetn),
    .shift_en (shift_en),
    .din      (rx_s2_ff),
    .q        (frame),
    .dout     (old_bit)
  );

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_ff   <= ST_IDLE;
      cnt_ff  <= 8'h00;
      bitn_ff <= 4'h0;
      pass_ff <= 1'b0;
      gap_ff  <= 8'h00;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (tick_ff && cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end
      case (st_ff)
        ST_IDLE: begin
          if (rx_s2_ff && !rx_prev_ff) begin
            st_ff  <= ST_START;
            cnt_ff <= HALF_BIT;
            gap_ff <= 8'h00;
          end else if (pass_ff && tick_ff) begin
            // A lone first frame must not pair with a later, unrelated one
            if (gap_ff == GAP_MAX) begin
              pass_ff <= 1'b0;
            end else begin
              gap_ff <= gap_ff + 8'h01;
            end
          end
        end
        ST_START: begin
          if (sample) begin
            if (rx_s2_ff) begin
              st_ff   <= ST_DATA;
              cnt_ff  <= BIT_LAST;
              bitn_ff <= 4'h0;
            end else begin
              st_ff <= ST_IDLE;
            end
          end
        end
        ST_DATA: begin
          if (sample) begin
            cnt_ff <= BIT_LAST;
            if (pass_ff && (rx_s2_ff != old_bit)) begin
              pass_ff <= 1'b0;
              st_ff   <= ST_IDLE;
            end else if (bitn_ff == LAST_BIT) begin
              st_ff   <= ST_IDLE;
              pass_ff <= ~pass_ff;
              done_ff <= pass_ff;
            end else begin
              bitn_ff <= bitn_ff + 4'h1;
            end
          end
        end
        default: begin
          st_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Code check and command decode
  wire       code_ok = IS_LARGE ?
    ((frame[`IRRX_POS_MATCH1] == mt_s2_ff[2]) &&
     (frame[`IRRX_POS_MATCH2] == mt_s2_ff[1])) :
    (frame[`IRRX_POS_MATCH1] &&
     (frame[`IRRX_POS_MATCH2] == mt_s2_ff[1]) &&
     (frame[`IRRX_POS_MATCH3] == mt_s2_ff[0]));
  wire       strobe  = done_ff && code_ok;
  wire [5:0] keys    = frame[`IRRX_POS_KEY1:`IRRX_POS_KEY6];
  wire [5:0] key_vec;
  wire       sel_h   = frame[`IRRX_POS_HOLD];
  wire       sel_1   = frame[`IRRX_POS_SEL1];
  wire       sel_2   = frame[`IRRX_POS_SEL2];

  // Key one is the first key bit received, so reverse the order
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi = gi + 1) begin : g_key
      assign key_vec[gi] = keys[5-gi];
    end
  endgenerate

  // Several key bits in one frame drive several outputs together
  wire [5:0] new_hold = (sel_h && !sel_1 && !sel_2) ? (key_vec & HOLD_MSK) : 6'h00;
  wire [9:0] new_sp   = {((!sel_h && !sel_1 && sel_2) ? (key_vec[3:0] & SEL2_MSK) : 4'h0),
                         ((!sel_h && sel_1 && !sel_2) ? (key_vec & SEL1_MSK) : 6'h00)};
  wire [1:0] new_tgl  = (!sel_h && !sel_1 && sel_2) ? (key_vec[5:4] & TGL_MSK) : 2'h0;

  // ==========================================================
  // Function outputs
  reg [12:0] hold_tmr_ff;
  reg [12:0] sp_tmr_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_function_out <= 6'h00;
      hold_tmr_ff       <= 13'h0000;
    end else if (strobe && new_hold != 6'h00) begin
      hold_function_out <= new_hold;
      hold_tmr_ff       <= HOLD_T;
    end else if (tick_ff && hold_tmr_ff != 13'h0000) begin
      hold_tmr_ff <= hold_tmr_ff - 13'h0001;
      if (hold_tmr_ff == 13'h0001) begin
        hold_function_out <= 6'h00;
      end
    end
  end

  // One shared pulse timer; a new single-shot command restarts it
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      single_pulse_out <= 10'h000;
      sp_tmr_ff        <= 13'h0000;
    end else if (strobe && new_sp != 10'h000) begin
      single_pulse_out <= single_pulse_out | new_sp;
      sp_tmr_ff        <= SP_T;
    end else if (tick_ff && sp_tmr_ff != 13'h0000) begin
      sp_tmr_ff <= sp_tmr_ff - 13'h0001;
      if (sp_tmr_ff == 13'h0001) begin
        single_pulse_out <= 10'h000;
      end
    end
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      toggle_function_out <= 2'h0;
    end else begin
      if (IS_DEP && (hold_function_out[0] || hold_function_out[1])) begin
        toggle_function_out <= {toggle_function_out[1] ^ (strobe & new_tgl[1]), 1'b0};
      end else if (strobe) begin
        toggle_function_out <= toggle_function_out ^ new_tgl;
      end
    end
  end

endmodule // irrx_decoder

// ==== inc/irrx_map.vh ====
// Constants for the infrared remote receiver decoder
`ifndef IRRX_MAP_VH
`define IRRX_MAP_VH

// ==========================================================
// Clocking
`define IRRX_CLK_HZ       20000000
`define IRRX_OSC_HZ       38000
`define IRRX_OSC_DIV      (`IRRX_CLK_HZ / `IRRX_OSC_HZ)

// ==========================================================
// Output timing, in milliseconds and in oscillator ticks
`define IRRX_SP_MS        107
`define IRRX_HOLD_MS      160
`define IRRX_SP_TICKS     ((`IRRX_SP_MS * `IRRX_OSC_HZ) / 1000)
`define IRRX_HOLD_TICKS   ((`IRRX_HOLD_MS * `IRRX_OSC_HZ) / 1000)

// ==========================================================
// Serial framing: bit and gap lengths in oscillator ticks, frame length in bits
`define IRRX_BIT_TICKS    16
`define IRRX_GAP_TICKS    64
`define IRRX_FRAME_BITS   12

// ==========================================================
// Frame bit positions after twelve shifts (first bit received is MSB)
`define IRRX_POS_HOLD     11
`define IRRX_POS_SEL1     10
`define IRRX_POS_SEL2     9
`define IRRX_POS_KEY1     8
`define IRRX_POS_KEY6     3
`define IRRX_POS_MATCH1   2
`define IRRX_POS_MATCH2   1
`define IRRX_POS_MATCH3   0

// ==========================================================
// Variants
`define IRRX_VAR_SMALL    2'h0
`define IRRX_VAR_DEP      2'h1
`define IRRX_VAR_LARGE    2'h2

`endif

// ==== design/irrx_shift.v ====
// Twelve-bit frame shift register used for the double-frame check
`timescale 1ns/100ps
module irrx_shift #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             clk,
  input  wire             resetn,
  // Shift control
  input  wire             shift_en,
  input  wire             din,
  // Contents
  output wire [WIDTH-1:0] q,
  output wire             dout
);

  reg [WIDTH-1:0] sr_ff;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sr_ff <= {WIDTH{1'b0}};
    end else if (shift_en) begin
      sr_ff <= {sr_ff[WIDTH-2:0], din};
    end
  end

  assign q    = sr_ff;
  // Oldest bit, pushed out by the next shift
  assign dout = sr_ff[WIDTH-1];

endmodule // irrx_shift

// ==== test/irrx_monitor.sv ====
// Checker for the infrared receiver decoder outputs
`timescale 1ns/100ps
module irrx_monitor #(
  parameter OSC_DIV    = 4,
  parameter BIT_TICKS  = 16,
  parameter SP_TICKS   = 20,
  parameter HOLD_TICKS = 30
) (
  // Clock and reset
  input wire       clk,
  input wire       resetn,
  // Serial line
  input wire       rx_in,
  // Function outputs
  input wire [5:0] hold_function_out,
  input wire [9:0] single_pulse_out,
  input wire [1:0] toggle_function_out
);
  localparam int FR  = 13 * BIT_TICKS * OSC_DIV + 16;
  localparam int SPC = SP_TICKS * OSC_DIV;
  localparam int HC  = HOLD_TICKS * OSC_DIV;
  reg  [15:0] quiet_ff;
  wire [15:0] nxt_quiet = rx_in ? 16'h0 : quiet_ff + {15'h0, ~&quiet_ff};
  reg  [9:0]  sp_q_ff;
  reg  [5:0]  hold_q_ff;
  reg  [15:0] sp_age_ff;
  reg  [15:0] hold_age_ff;
  wire [15:0] nxt_sp_age = |(single_pulse_out & ~sp_q_ff) ? 16'h0 :
    sp_age_ff + {15'h0, ~&sp_age_ff};
  wire [15:0] nxt_hold_age = |(hold_function_out & ~hold_q_ff) ? 16'h0 :
    hold_age_ff + {15'h0, ~&hold_age_ff};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ==========================================================
  // Cycles since the line was last high; outputs only move near a frame, except the falls at timer expiry
  always @(posedge clk or negedge resetn) begin
    if (!resetn) quiet_ff <= 16'h0;
    else quiet_ff <= nxt_quiet;
  end
  // Cycles since a bit last rose; the line may stay high past the strobe
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sp_q_ff     <= 10'h000;
      hold_q_ff   <= 6'h00;
      sp_age_ff   <= 16'h0;
      hold_age_ff <= 16'h0;
    end else begin
      sp_q_ff     <= single_pulse_out;
      hold_q_ff   <= hold_function_out;
      sp_age_ff   <= nxt_sp_age;
      hold_age_ff <= nxt_hold_age;
    end
  end
  chk_reset_clear: assert property ($rose(resetn) |->
    {hold_function_out, single_pulse_out, toggle_function_out} == 18'h0)
    else $error("outputs not clear after reset");
  chk_pulse_max: assert property (|single_pulse_out |-> quiet_ff < FR + SPC + OSC_DIV)
    else $error("single pulse too long");
  chk_pulse_min: assert property ($fell(|single_pulse_out) |-> sp_age_ff >= SPC - OSC_DIV)
    else $error("single pulse too short");
  chk_pulse_cause: assert property ($rose(|single_pulse_out) |-> quiet_ff < FR)
    else $error("single pulse without a frame");
  chk_hold_max: assert property (|hold_function_out |-> quiet_ff < FR + HC + OSC_DIV)
    else $error("hold output outlives its timer");
  chk_hold_min: assert property ($fell(|hold_function_out) |-> hold_age_ff >= HC - OSC_DIV)
    else $error("hold output dropped early");
  chk_hold_cause: assert property ($changed(hold_function_out) && |hold_function_out
    |-> quiet_ff < FR) else $error("hold set changed without a frame");
  chk_toggle_cause: assert property ($changed(toggle_function_out) |-> quiet_ff < FR)
    else $error("toggle changed without a frame");
  cover property ($rose(|hold_function_out));
  cover property ($rose(|single_pulse_out));
  cover property ($changed(toggle_function_out));
endmodule // irrx_monitor

bind irrx_decoder irrx_monitor #(.OSC_DIV(OSC_DIV), .BIT_TICKS(BIT_TICKS),
  .SP_TICKS(SP_TICKS), .HOLD_TICKS(HOLD_TICKS)) mon (.clk(clk), .resetn(resetn),
  .rx_in(rx_in), .hold_function_out(hold_function_out),
  .single_pulse_out(single_pulse_out), .toggle_function_out(toggle_function_out));

// ==== test/irrx_tx_model.sv ====
// Transmitter model driving command frames onto the demodulated line
`timescale 1ns/100ps
module irrx_tx_model #(
  parameter BIT_CLKS = 16
) (
  // Clock
  input wire clk,
  // Demodulated line
  output reg rx_in
);
  initial rx_in = 1'b0;
  // ==========================================================
  // Start bit, twelve bits first-sent-first, then idle low for two bits
  task send_frame(input [11:0] w);
    integer j;
    begin
      @(negedge clk);
      rx_in = 1'b1;
      repeat (BIT_CLKS) @(negedge clk);
      for (j = 11; j >= 0; j = j - 1) begin
        rx_in = w[j];
        repeat (BIT_CLKS) @(negedge clk);
      end
      rx_in = 1'b0;
      repeat (2 * BIT_CLKS - 1) @(negedge clk);
    end
  endtask
  task send_pair(input [11:0] a, input [11:0] b);
    begin
      send_frame(a);
      send_frame(b);
    end
  endtask
endmodule // irrx_tx_model

// ==== test/tb_ir_remote_receiver_decoder.sv ====
// Self-checking bench for the infrared receiver decoder
`timescale 1ns/100ps
module tb_ir_remote_receiver_decoder;
  localparam DIV = 4;
  localparam BT  = 4;
  localparam HT  = 200;
  reg         clk = 1'b0;
  reg         resetn = 1'b0;
  reg         m1 = 1'b1;
  reg         m2 = 1'b0;
  reg         m3 = 1'b0;
  wire        rx_in;
  wire [5:0]  hold;
  wire [9:0]  sp;
  wire [1:0]  tg;
  wire [5:0]  hold_s;
  wire [9:0]  sp_s;
  wire [1:0]  tg_s;
  wire [5:0]  hold_d;
  wire [9:0]  sp_d;
  wire [1:0]  tg_d;
  reg  [31:0] seed = 32'h00009D34;
  reg  [1:0]  e_tg = 2'h0;
  reg  [1:0]  e_tgd = 2'h0;
  integer     err_count = 0;
  integer     samples_checked = 0;
  integer     cyc = 0;
  integer     i;

  always #25 clk = ~clk;

  irrx_decoder #(.VARIANT(2'h2), .OSC_DIV(DIV), .BIT_TICKS(BT), .GAP_TICKS(40),
    .SP_TICKS(20), .HOLD_TICKS(HT)) dut (.clk(clk), .resetn(resetn), .rx_in(rx_in),
    .match_bit_one(m1), .match_bit_two(m2), .match_bit_three(m3),
    .hold_function_out(hold), .single_pulse_out(sp), .toggle_function_out(tg));
  irrx_tx_model #(.BIT_CLKS(BT * DIV)) tx (.clk(clk), .rx_in(rx_in));
  irrx_decoder #(.VARIANT(2'h0), .OSC_DIV(DIV), .BIT_TICKS(BT), .GAP_TICKS(40),
    .SP_TICKS(20), .HOLD_TICKS(HT)) dut_sml (.clk(clk), .resetn(resetn), .rx_in(rx_in),
    .match_bit_one(m1), .match_bit_two(m2), .match_bit_three(m3),
    .hold_function_out(hold_s), .single_pulse_out(sp_s), .toggle_function_out(tg_s));
  irrx_decoder #(.VARIANT(2'h1), .OSC_DIV(DIV), .BIT_TICKS(BT), .GAP_TICKS(40),
    .SP_TICKS(20), .HOLD_TICKS(HT)) dut_dep (.clk(clk), .resetn(resetn), .rx_in(rx_in),
    .match_bit_one(m1), .match_bit_two(m2), .match_bit_three(m3),
    .hold_function_out(hold_d), .single_pulse_out(sp_d), .toggle_function_out(tg_d));

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  task check(input [17:0] got, input [17:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // ==========================================================
  // Kind is {hold, select1, select2}; key bit 0 is key one
  task cmd(input [2:0] kind, input [5:0] k, input ok, input integer n, input [11:0] flip);
    reg [17:0] e;
    reg [17:0] es;
    reg [17:0] ed;
    reg [11:0] w;
    integer    j;
    begin
      w = {kind, 6'h00, m1 ^ !ok, m2 ^ !ok, m3};
      for (j = 0; j < 6; j = j + 1) w[8 - j] = k[j];
      e = 18'h0;
      if (ok && flip == 12'h0) begin
        if (kind == 3'h4) e[17:12] = k;
        if (kind == 3'h2) e[7:2] = k;
        if (kind == 3'h1) begin
          e[11:8] = k[3:0];
          e_tg = e_tg ^ k[5:4];
        end
      end
      e[1:0] = e_tg;
      es = 18'h0;
      ed = 18'h0;
      // Small variants also need the received first match bit high
      if (ok && m1 && flip == 12'h0) begin
        if (kind == 3'h4) begin
          es[17:12] = k & 6'h1F;
          ed[17:12] = k & 6'h1F;
          if (k[1:0] != 2'h0) e_tgd[0] = 1'b0;
        end
        if (kind == 3'h2) begin
          es[7:2] = k & 6'h1F;
          ed[7:2] = k & 6'h07;
        end
        if (kind == 3'h1) e_tgd = e_tgd ^ k[5:4];
      end
      ed[1:0] = e_tgd;
      repeat (n) tx.send_pair(w, w ^ flip);
      check({hold, sp, tg}, e);
      check({hold_s, sp_s, tg_s}, es);
      check({hold_d, sp_d, tg_d}, ed);
      repeat (HT * DIV + 64) @(negedge clk);
      check({hold, sp, tg}, {16'h0, e_tg});
      check({hold_s, sp_s, tg_s}, 18'h0);
      check({hold_d, sp_d, tg_d}, {16'h0, e_tgd});
      $display("test done kind=%h keys=%h", kind, k);
    end
  endtask

  task wrap_up;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0)
        $display("bench passed");
      else
        $display("bench failed");
      $finish;
    end
  endtask

  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 80000) begin
      err_count = err_count + 1;
      wrap_up;
    end
  end

  initial begin
    seed = xs(seed);
    {m1, m2, m3} = seed[2:0];
    if ({m1, m2} == 2'h0) m1 = 1'b1;
    repeat (2) @(negedge clk);
    resetn = 1'b1;
    repeat (4) @(negedge clk);
    for (i = 0; i < 6; i = i + 1) begin
      cmd(3'h4, 6'h01 << i, 1'b1, 1, 12'h0);
      cmd(3'h2, 6'h01 << i, 1'b1, 1, 12'h0);
      cmd(3'h1, 6'h01 << i, 1'b1, 1, 12'h0);
    end
    cmd(3'h4, 6'h3F, 1'b1, 3, 12'h0);
    cmd(3'h1, 6'h30, 1'b1, 1, 12'h0);
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      cmd(seed[4:2], seed[10:5], 1'b0, 1, 12'h0);
      cmd(3'h2, seed[10:5], 1'b1, 1, 12'h001 << (seed[15:12] % 12));
      cmd(3'h4, seed[21:16], 1'b1, 1, 12'h0);
    end
    wrap_up;
  end
endmodule // tb_ir_remote_receiver_decoder
